// file: src/ccd_pkg.sv
// Constants for the contactless command decoder.
// Assumes a framer that strips the two check bytes and flags their result.
package ccd_pkg;
    // ------------------------------------------------------------
    // Command bytes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_POLL = 8'h05;
    localparam logic [7:0] CMD_ATTRIB = 8'h1d;
    localparam logic [7:0] CMD_HALT = 8'h50;
    localparam logic [3:0] MARK_LOW = 4'h5;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [7:0] AFI_ANY = 8'h00;

    // ------------------------------------------------------------
    // Active-state operation codes (low nibble)
    // ------------------------------------------------------------
    localparam logic [3:0] OP_SET_ZONE = 4'h1;
    localparam logic [3:0] OP_RD_USER = 4'h2;
    localparam logic [3:0] OP_WR_USER = 4'h3;
    localparam logic [3:0] OP_WR_SYS = 4'h4;
    localparam logic [3:0] OP_RD_SYS = 4'h6;
    localparam logic [3:0] OP_VERIFY = 4'h8;
    localparam logic [3:0] OP_CHECKSUM = 4'h9;
    localparam logic [3:0] OP_DESELECT = 4'ha;
    localparam logic [3:0] OP_IDLE = 4'hb;
    localparam logic [3:0] OP_CHK_PW = 4'hc;

    // ------------------------------------------------------------
    // Frame layout (bytes before the check bytes)
    // ------------------------------------------------------------
    localparam int FRAME_DEPTH = 9;
    localparam logic [3:0] LEN_POLL = 4'h3;
    localparam logic [3:0] LEN_MARK = 4'h1;
    localparam logic [3:0] LEN_HALT = 4'h5;
    localparam logic [3:0] LEN_ATTRIB = 4'h9;
    localparam int IDX_AFI = 1;
    localparam int IDX_PARAM = 2;
    localparam int IDX_PUPI = 1;
    localparam int IDX_CID = 8;
    localparam int PARAM_SEL_BIT = 3;
    localparam logic [2:0] SLOT_CODE_MAX = 3'h4;

    typedef enum {TAG_IDLE, TAG_READY, TAG_ACTIVE, TAG_HALT} ccd_tag_e;
endpackage

// file: src/ccd_slot_rng.sv
// Free-running pseudo-random slot picker for the polling slots.
// Assumes the code presented is already checked to be 0..4.
`timescale 1ns/1ps
module ccd_slot_rng #(
    parameter int LFSR_W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Slot-count code and chosen slot index (0 = first slot)
    input wire logic [2:0] slot_code,
    output logic [3:0] slot_pick
);
    logic [LFSR_W-1:0] lfsr_reg;
    logic [3:0] mask;

    // Taps for a maximal 16-bit sequence; never reaches all zeros
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lfsr_reg <= {{(LFSR_W-1){1'b0}}, 1'b1};
        end else begin
            lfsr_reg <= {lfsr_reg[LFSR_W-2:0],
                lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        end
    end

    always_comb begin
        mask = 4'((5'h01 << slot_code) - 5'h01);
        slot_pick = lfsr_reg[3:0] & mask;
    end
endmodule

// file: src/ccd_decoder.sv
// Command decoder, polling responder and access policy for the tag.
// Assumes a byte framer: rx_valid per byte, then one rx_end pulse with rx_crc_ok.
`timescale 1ns/1ps
module ccd_decoder (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Received frame from the byte framer
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_end,
    input wire logic rx_crc_ok,
    // System-zone content and security state
    input wire logic [7:0] afi_stored,
    input wire logic [31:0] pupi_stored,
    input wire logic personalized,
    input wire logic zone_sec_met,
    input wire logic fuse_blown,
    // Anticollision answers
    output logic atqb_send,
    output logic attrib_ack,
    output logic halt_ack,
    output logic [3:0] cid_out,
    output logic tag_active,
    output logic wakeup_sel,
    output logic [4:0] slot_count,
    // Active-state commands and access
    output logic cmd_strobe,
    output logic [3:0] cmd_op,
    output logic cmd_unsup,
    output logic user_rd_grant,
    output logic user_wr_grant,
    output logic sys_rd_grant,
    output logic sys_wr_grant
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic afi_match(input logic [7:0] rx, input logic [7:0] own);
        if (rx == ccd_pkg::AFI_ANY) begin
            afi_match = 1'b1;
        end else if (rx[3:0] == ccd_pkg::NIB_ZERO) begin
            afi_match = (rx[7:4] == own[7:4]);
        end else begin
            afi_match = (rx == own);
        end
    endfunction

    function automatic logic [4:0] slots_of(input logic [2:0] code);
        slots_of = 5'(5'h01 << code);
    endfunction

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    logic [7:0] frame_mem [0:ccd_pkg::FRAME_DEPTH-1];
    logic [3:0] len_reg;
    logic [31:0] rx_pupi;
    logic pupi_ok;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            len_reg <= 4'h0;
        end else if (rx_end) begin
            len_reg <= 4'h0;
        end else if (rx_valid && len_reg != 4'hf) begin
            len_reg <= len_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rx_valid && len_reg < 4'(ccd_pkg::FRAME_DEPTH)) begin
            frame_mem[len_reg] <= rx_byte;
        end
    end

    // Identifier from the system zone, sent low byte first
    assign rx_pupi = {frame_mem[ccd_pkg::IDX_PUPI+3], frame_mem[ccd_pkg::IDX_PUPI+2],
                      frame_mem[ccd_pkg::IDX_PUPI+1], frame_mem[ccd_pkg::IDX_PUPI]};
    assign pupi_ok = (rx_pupi == pupi_stored);

    // ------------------------------------------------------------
    // Decode at end of frame
    // ------------------------------------------------------------
    ccd_pkg::ccd_tag_e tag_reg;
    logic [3:0] cid_reg;
    logic [3:0] pick_reg;
    logic [2:0] code_reg;
    logic [3:0] slot_pick;
    logic [7:0] cmd_b;
    logic [7:0] prm_b;
    logic frame_ok;
    logic is_poll;
    logic poll_ok;
    logic is_mark;
    logic mark_ok;
    logic attrib_ok;
    logic halt_ok;
    logic act_hit;
    logic op_known;

    assign cmd_b = frame_mem[0];
    assign prm_b = frame_mem[ccd_pkg::IDX_PARAM];
    // Check bytes are verified by the framer; a bad frame is dropped whole
    assign frame_ok = rx_end && rx_crc_ok;

    always_comb begin
        is_poll = frame_ok && len_reg == ccd_pkg::LEN_POLL && cmd_b == ccd_pkg::CMD_POLL;
        poll_ok = is_poll && prm_b[7:4] == ccd_pkg::NIB_ZERO
            && prm_b[2:0] <= ccd_pkg::SLOT_CODE_MAX
            && afi_match(frame_mem[ccd_pkg::IDX_AFI], afi_stored)
            && tag_reg != ccd_pkg::TAG_ACTIVE
            && (tag_reg != ccd_pkg::TAG_HALT || prm_b[ccd_pkg::PARAM_SEL_BIT]);
        is_mark = frame_ok && len_reg == ccd_pkg::LEN_MARK
            && cmd_b[3:0] == ccd_pkg::MARK_LOW && cmd_b[7:4] != ccd_pkg::NIB_ZERO;
        mark_ok = is_mark && tag_reg == ccd_pkg::TAG_READY
            && code_reg != 3'h0 && cmd_b[7:4] == pick_reg;
        attrib_ok = frame_ok && len_reg == ccd_pkg::LEN_ATTRIB
            && cmd_b == ccd_pkg::CMD_ATTRIB && tag_reg == ccd_pkg::TAG_READY && pupi_ok;
        halt_ok = frame_ok && len_reg >= ccd_pkg::LEN_HALT && cmd_b == ccd_pkg::CMD_HALT
            && tag_reg == ccd_pkg::TAG_READY && pupi_ok;
        act_hit = frame_ok && tag_reg == ccd_pkg::TAG_ACTIVE
            && cmd_b[7:4] == cid_reg;
        case (cmd_b[3:0])
            ccd_pkg::OP_SET_ZONE, ccd_pkg::OP_RD_USER, ccd_pkg::OP_WR_USER,
            ccd_pkg::OP_WR_SYS, ccd_pkg::OP_RD_SYS, ccd_pkg::OP_VERIFY,
            ccd_pkg::OP_CHECKSUM, ccd_pkg::OP_DESELECT, ccd_pkg::OP_IDLE,
            ccd_pkg::OP_CHK_PW: op_known = 1'b1;
            default: op_known = 1'b0;
        endcase
    end

    ccd_slot_rng #(.LFSR_W(16)) u_rng (
        .clk_sys(clk_sys),
        .reset(reset),
        .slot_code(prm_b[2:0]),
        .slot_pick(slot_pick)
    );

    // ------------------------------------------------------------
    // Tag state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tag_reg <= ccd_pkg::TAG_IDLE;
            cid_reg <= 4'h0;
            pick_reg <= 4'h0;
            code_reg <= 3'h0;
        end else begin
            case (tag_reg)
                ccd_pkg::TAG_IDLE, ccd_pkg::TAG_HALT, ccd_pkg::TAG_READY: begin
                    if (poll_ok) begin
                        tag_reg <= ccd_pkg::TAG_READY;
                        pick_reg <= slot_pick;
                        code_reg <= prm_b[2:0];
                    end else if (attrib_ok) begin
                        tag_reg <= ccd_pkg::TAG_ACTIVE;
                        cid_reg <= frame_mem[ccd_pkg::IDX_CID][7:4];
                    end else if (halt_ok) begin
                        tag_reg <= ccd_pkg::TAG_HALT;
                    end
                end
                ccd_pkg::TAG_ACTIVE: begin
                    if (act_hit && cmd_b[3:0] == ccd_pkg::OP_DESELECT) begin
                        tag_reg <= ccd_pkg::TAG_HALT;
                    end else if (act_hit && cmd_b[3:0] == ccd_pkg::OP_IDLE) begin
                        tag_reg <= ccd_pkg::TAG_IDLE;
                    end
                end
                default: tag_reg <= ccd_pkg::TAG_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Answers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            atqb_send <= 1'b0;
            attrib_ack <= 1'b0;
            halt_ack <= 1'b0;
            wakeup_sel <= 1'b0;
            slot_count <= 5'h01;
        end else begin
            // First slot answers at once; later slots wait for their marker
            atqb_send <= (poll_ok && slot_pick == 4'h0) || mark_ok;
            attrib_ack <= attrib_ok;
            halt_ack <= halt_ok;
            if (is_poll) begin
                wakeup_sel <= prm_b[ccd_pkg::PARAM_SEL_BIT];
                slot_count <= slots_of(prm_b[2:0]);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tag_active <= 1'b0;
            cid_out <= 4'h0;
        end else begin
            tag_active <= (tag_reg == ccd_pkg::TAG_ACTIVE);
            cid_out <= cid_reg;
        end
    end

    // ------------------------------------------------------------
    // Active commands and access policy
    // ------------------------------------------------------------
    logic zone_open;
    // Policy is fixed logic; only fuses and zone security feed it
    assign zone_open = !personalized || zone_sec_met;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cmd_strobe <= 1'b0;
            cmd_op <= 4'h0;
            cmd_unsup <= 1'b0;
            user_rd_grant <= 1'b0;
            user_wr_grant <= 1'b0;
            sys_rd_grant <= 1'b0;
            sys_wr_grant <= 1'b0;
        end else begin
            cmd_strobe <= act_hit && op_known;
            cmd_unsup <= act_hit && !op_known;
            if (act_hit) begin
                cmd_op <= cmd_b[3:0];
            end
            user_rd_grant <= act_hit && cmd_b[3:0] == ccd_pkg::OP_RD_USER
                && zone_open;
            user_wr_grant <= act_hit && cmd_b[3:0] == ccd_pkg::OP_WR_USER
                && zone_open;
            sys_rd_grant <= act_hit && cmd_b[3:0] == ccd_pkg::OP_RD_SYS;
            sys_wr_grant <= act_hit && cmd_b[3:0] == ccd_pkg::OP_WR_SYS
                && !fuse_blown;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_quiet_active: assert property (
        $past(tag_reg) == ccd_pkg::TAG_ACTIVE && $past(is_poll) |-> !atqb_send)
        else $error("active tag answered polling");
    a_bad_frame: assert property (
        rx_end && !rx_crc_ok |=> !atqb_send && !attrib_ack && !cmd_strobe)
        else $error("errored frame answered");
    a_afi_gate: assert property (
        is_poll && !afi_match(frame_mem[ccd_pkg::IDX_AFI], afi_stored) |=> !atqb_send)
        else $error("answer with wrong family id");
    a_afi_wild: assert property (
        is_poll && frame_mem[ccd_pkg::IDX_AFI] == ccd_pkg::AFI_ANY
        && tag_reg == ccd_pkg::TAG_IDLE && prm_b == 8'h00 |=> atqb_send)
        else $error("wildcard poll not answered");
    a_param_rsvd: assert property (
        is_poll && prm_b[2:0] > ccd_pkg::SLOT_CODE_MAX |=> !atqb_send && $stable(tag_reg))
        else $error("reserved slot code used");
    a_slot_count: assert property (
        is_poll |=> slot_count == slots_of($past(prm_b[2:0])))
        else $error("slot count wrong");
    a_marker_gate: assert property (
        is_mark && cmd_b[7:4] != pick_reg |=> !atqb_send)
        else $error("marker answered in wrong slot");
    a_cid_gate: assert property (
        cmd_strobe |-> $past(cmd_b[7:4]) == cid_out)
        else $error("command for another card acted on");
    a_fuse_lock: assert property (
        fuse_blown |=> !sys_wr_grant)
        else $error("system write past fuse");
    a_open_zone: assert property (
        act_hit && !personalized && cmd_b[3:0] == ccd_pkg::OP_WR_USER
        |=> user_wr_grant ##1 !user_wr_grant)
        else $error("open zone refused");
    a_sel_bit: assert property (
        is_poll |=> wakeup_sel == $past(prm_b[ccd_pkg::PARAM_SEL_BIT]))
        else $error("selector bit wrong");
    // Identifier mismatch must leave the tag unselected and not halted
    a_pupi_gate: assert property (
        frame_ok && !pupi_ok |=> !attrib_ack && !halt_ack)
        else $error("select or halt with wrong identifier");
    a_halt_wake: assert property (
        is_poll && tag_reg == ccd_pkg::TAG_HALT && !prm_b[ccd_pkg::PARAM_SEL_BIT]
        |=> !atqb_send)
        else $error("halted tag answered request");
    a_unsup_op: assert property (
        act_hit && !op_known |=> cmd_unsup && !cmd_strobe)
        else $error("unsupported command not flagged");

    c_poll: cover property (poll_ok ##1 atqb_send);
    c_attrib: cover property (attrib_ok ##1 tag_active [*2]);
    c_marker: cover property (mark_ok);
    c_active_cmd: cover property (cmd_strobe && cmd_op == ccd_pkg::OP_RD_SYS);
endmodule

// file: verification/ccd_reader_model.sv
// Reader-side model: sends whole frames straight to the decoder, in place of the tag's byte framer.
// Assumes the bench calls send_frame between falling edges of clk_sys.
`timescale 1ns/1ps
module ccd_reader_model (
    // Clock
    input wire logic clk_sys,
    // Frame towards the decoder
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_end,
    output logic rx_crc_ok
);
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_end = 1'b0;
        rx_crc_ok = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------
    task automatic send_frame(input logic [7:0] bytes [$], input logic crc_good);
        for (int i = 0; i < bytes.size(); i++) begin
            @(negedge clk_sys);
            rx_valid = 1'b1;
            rx_byte = bytes[i];
        end
        @(negedge clk_sys);
        rx_valid = 1'b0;
        // Stale byte must not look valid to a sloppy decoder
        rx_byte = ~rx_byte;
        rx_end = 1'b1;
        rx_crc_ok = crc_good;
        @(negedge clk_sys);
        rx_end = 1'b0;
        rx_crc_ok = ~crc_good;
    endtask
endmodule

// file: verification/contactless_command_decoder_tb_top.sv
// Self-checking bench for the tag command decoder.
// Assumes answers pulse in the cycle right after the frame end marker.
`timescale 1ns/1ps
module contactless_command_decoder_tb_top;
    logic clk_sys, reset;
    logic rx_valid, rx_end, rx_crc_ok;
    logic [7:0] rx_byte, afi_stored;
    logic [31:0] pupi_stored;
    logic personalized, zone_sec_met, fuse_blown;
    logic atqb_send, attrib_ack, halt_ack, tag_active, wakeup_sel;
    logic cmd_strobe, cmd_unsup, user_rd_grant, user_wr_grant, sys_rd_grant, sys_wr_grant;
    logic [3:0] cid_out, cmd_op;
    logic [4:0] slot_count;
    logic [8:0] pulses, exp_p;
    logic sup, acc_open;
    logic [15:0] afi_tab [8];
    logic [7:0] afi_hit;
    int err_count, n_tests;
    logic [31:0] hits;
    localparam logic [8:0] ATQ = 9'h100;
    localparam logic [8:0] ALL = 9'h1ff;

    assign pulses = {atqb_send, attrib_ack, halt_ack, cmd_strobe, cmd_unsup,
                     user_rd_grant, user_wr_grant, sys_rd_grant, sys_wr_grant};

    ccd_reader_model i_ccd_reader_model (.clk_sys(clk_sys), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok));

    ccd_decoder i_ccd_decoder (.clk_sys(clk_sys), .reset(reset), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok),
        .afi_stored(afi_stored), .pupi_stored(pupi_stored), .personalized(personalized),
        .zone_sec_met(zone_sec_met), .fuse_blown(fuse_blown), .atqb_send(atqb_send),
        .attrib_ack(attrib_ack), .halt_ack(halt_ack), .cid_out(cid_out),
        .tag_active(tag_active), .wakeup_sel(wakeup_sel), .slot_count(slot_count),
        .cmd_strobe(cmd_strobe), .cmd_op(cmd_op), .cmd_unsup(cmd_unsup),
        .user_rd_grant(user_rd_grant), .user_wr_grant(user_wr_grant),
        .sys_rd_grant(sys_rd_grant), .sys_wr_grant(sys_wr_grant));

    // ------------------------------------------------------------
    // Clock and helpers
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Answer pulses are looked at in the one cycle they stand
    task automatic xfer(input logic [7:0] b [$], input logic ok, input logic [8:0] mask,
                        input logic [8:0] exp);
        i_ccd_reader_model.send_frame(b, ok);
        check({23'h0, pulses & mask}, {23'h0, exp});
    endtask

    task automatic poll(input logic [7:0] afi, input logic [7:0] prm, input logic ok,
                        input logic [8:0] exp);
        xfer('{ccd_pkg::CMD_POLL, afi, prm}, ok, ALL, exp);
    endtask

    task automatic attrib(input logic [3:0] cid);
        xfer('{ccd_pkg::CMD_ATTRIB, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h00,
               {cid, 4'h0}}, 1'b1, ALL, 9'h080);
        @(negedge clk_sys);
        check({27'h0, cid_out, tag_active}, {27'h0, cid, 1'b1});
    endtask

    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Run needs under two thousand cycles; ten times that means a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        err_count = 0;
        n_tests = 0;
        reset = 1'b1;
        afi_stored = 8'h31;
        pupi_stored = 32'h4433_2211;
        personalized = 1'b0;
        zone_sec_met = 1'b0;
        fuse_blown = 1'b0;
        // Stored/received family identifier pairs and whether they match
        afi_tab = '{16'h3100, 16'h3130, 16'h3131, 16'h3132, 16'h3140, 16'h3101,
                    16'h0707, 16'h0737};
        afi_hit = 8'b0100_0111;
        repeat (5) @(negedge clk_sys);
        check({17'h0, cid_out, tag_active, wakeup_sel, slot_count, cmd_op}, 32'h0000_0010);
        reset = 1'b0;
        for (int i = 0; i < 8; i++) begin
            afi_stored = afi_tab[i][15:8];
            poll(afi_tab[i][7:0], 8'h00, 1'b1, afi_hit[i] ? ATQ : 9'h0);
        end
        afi_stored = 8'h31;
        poll(8'h00, 8'h00, 1'b0, 9'h0);
        for (int c = 0; c < 5; c++) begin
            xfer('{ccd_pkg::CMD_POLL, 8'h00, {4'h0, c[0], c[2:0]}}, 1'b1, 9'h0ff, 9'h0);
            check({27'h0, slot_count}, 32'h1 << c);
            check({31'h0, wakeup_sel}, {31'h0, c[0]});
        end
        poll(8'h00, 8'h05, 1'b1, 9'h0);
        poll(8'h00, 8'h10, 1'b1, 9'h0);
        // Sixteen slots: the tag answers exactly once, at the poll or one marker
        xfer('{ccd_pkg::CMD_POLL, 8'h00, 8'h04}, 1'b1, 9'h0, 9'h0);
        hits = atqb_send;
        for (int s = 1; s < 16; s++) begin
            xfer('{{s[3:0], ccd_pkg::MARK_LOW}}, 1'b1, 9'h0, 9'h0);
            hits += atqb_send;
        end
        check(hits, 1);
        poll(8'h00, 8'h00, 1'b1, ATQ);
        xfer('{ccd_pkg::CMD_ATTRIB, 8'h11, 8'h22, 8'h33, 8'h45, 8'h00, 8'h00, 8'h00,
               8'h50}, 1'b1, ALL, 9'h0);
        attrib(4'h5);
        poll(8'h00, 8'h00, 1'b1, 9'h0);
        poll(8'h00, 8'h08, 1'b1, 9'h0);
        for (int cfg = 0; cfg < 3; cfg++) begin
            personalized = (cfg != 0);
            zone_sec_met = (cfg == 2);
            fuse_blown = (cfg == 1);
            acc_open = !personalized || zone_sec_met;
            for (int op = 0; op < 16; op++) begin
                if (op != 10 && op != 11) begin
                    sup = op inside {1, 2, 3, 4, 6, 8, 9, 12};
                    exp_p = {3'b000, sup, !sup, op == 2 && acc_open, op == 3 && acc_open,
                             op == 6, op == 4 && !fuse_blown};
                    xfer('{{4'h5, op[3:0]}}, 1'b1, ALL, exp_p);
                    if (sup) check({28'h0, cmd_op}, op);
                end
            end
        end
        xfer('{8'h52}, 1'b0, ALL, 9'h0);
        xfer('{8'h32}, 1'b1, ALL, 9'h0);
        xfer('{8'h5a}, 1'b1, ALL, 9'h020);
        @(negedge clk_sys);
        check({31'h0, tag_active}, 32'h0);
        poll(8'h00, 8'h00, 1'b1, 9'h0);
        poll(8'h00, 8'h08, 1'b1, ATQ);
        xfer('{ccd_pkg::CMD_HALT, 8'h11, 8'h22, 8'h33, 8'h45}, 1'b1, ALL, 9'h0);
        xfer('{ccd_pkg::CMD_HALT, 8'h11, 8'h22, 8'h33, 8'h44}, 1'b1, ALL, 9'h040);
        poll(8'h00, 8'h00, 1'b1, 9'h0);
        poll(8'h00, 8'h08, 1'b1, ATQ);
        attrib(4'h0);
        xfer('{8'h0b}, 1'b1, ALL, 9'h020);
        poll(8'h00, 8'h00, 1'b1, ATQ);
        give_verdict();
    end
endmodule
